// [hdl/xbar_pkg.sv]
package xbar_pkg;
  // ----------------------------------------
  // Register map (word addresses on the bus)
  // ----------------------------------------
  localparam logic [7:0] select_low_index = 8'he1;
  localparam logic [7:0] select_high_index = 8'he2;
  localparam logic [7:0] route_status_index = 8'he3;
  localparam logic [7:0] spi_mode_index = 8'he4;
  localparam logic [7:0] select_low_reset = 8'h00;
  localparam logic [7:0] select_high_reset = 8'h00;
  localparam logic [7:0] select_low_mask = 8'h3f;
  localparam logic [7:0] select_high_mask = 8'hfb;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int async_serial_route_en_pos = 0;
  localparam int serial_periph_route_en_pos = 1;
  localparam int twowire_route_en_pos = 2;
  localparam int sysclock_out_route_en_pos = 3;
  localparam int comparator_sync_route_en_pos = 4;
  localparam int comparator_async_route_en_pos = 5;
  localparam int capture_lines_route_sel_pos = 0;
  localparam int counter_ext_input_route_en_pos = 3;
  localparam int timer0_input_route_en_pos = 4;
  localparam int timer1_input_route_en_pos = 5;
  localparam int matrix_enable_pos = 6;
  localparam int pullup_disable_pos = 7;
  // ----------------------------------------
  // Routed peripheral outputs, one bit each
  // ----------------------------------------
  localparam int num_func = 14;
  localparam int fn_tx = 0;
  localparam int fn_rx = 1;
  localparam int fn_sck = 2;
  localparam int fn_miso = 3;
  localparam int fn_mosi = 4;
  localparam int fn_nss = 5;
  localparam int fn_sda = 6;
  localparam int fn_scl = 7;
  localparam int fn_cp_async = 8;
  localparam int fn_cp_sync = 9;
  localparam int fn_system_clock_output = 10;
  localparam int fn_capture_line_0 = 11;
  localparam int fn_cex1 = 12;
  localparam int fn_cex2 = 13;
  localparam logic [1:0] sync_reset = 2'h0;
  typedef enum logic [1:0] {bus_idle, bus_ack} bus_state_t;
endpackage

// [hdl/xbar_cfg_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface xbar_cfg_if;
  logic [7:0] low;
  logic [7:0] high;
  logic four_wire;
  logic [13:0] route_en;
  modport regs(output low, output high, output four_wire, input route_en);
  modport decode(input low, input high, input four_wire, output route_en);
endinterface
`default_nettype wire

// [hdl/xbar_route_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module xbar_route_decode
  import xbar_pkg::*;
(
  xbar_cfg_if.decode cfg
);
  logic [1:0] cap_sel;
  always_comb begin
    cap_sel = cfg.high[capture_lines_route_sel_pos +: 2];
    cfg.route_en = '0;
    cfg.route_en[fn_tx] = cfg.low[async_serial_route_en_pos];
    cfg.route_en[fn_rx] = cfg.low[async_serial_route_en_pos];
    cfg.route_en[fn_sck] = cfg.low[serial_periph_route_en_pos];
    cfg.route_en[fn_miso] = cfg.low[serial_periph_route_en_pos];
    cfg.route_en[fn_mosi] = cfg.low[serial_periph_route_en_pos];
    cfg.route_en[fn_nss] = cfg.low[serial_periph_route_en_pos] & cfg.four_wire;
    cfg.route_en[fn_sda] = cfg.low[twowire_route_en_pos];
    cfg.route_en[fn_scl] = cfg.low[twowire_route_en_pos];
    cfg.route_en[fn_cp_async] = cfg.low[comparator_async_route_en_pos];
    cfg.route_en[fn_cp_sync] = cfg.low[comparator_sync_route_en_pos];
    cfg.route_en[fn_system_clock_output] = cfg.low[sysclock_out_route_en_pos];
    cfg.route_en[fn_capture_line_0] = (cap_sel != 2'h0);
    cfg.route_en[fn_cex1] = (cap_sel[1] == 1'b1);
    cfg.route_en[fn_cex2] = (cap_sel == 2'h3);
    // Nothing leaves the block while the matrix is off
    if (!cfg.high[matrix_enable_pos]) begin
      cfg.route_en = '0;
    end
  end
endmodule
`default_nettype wire

// [hdl/port_crossbar_routing.sv]
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module port_crossbar_routing
  import xbar_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic spi_four_wire,
  input wire logic comparator_async_in,
  input wire logic [13:0] func_out,
  output logic [13:0] func_drive,
  output logic [13:0] func_oe,
  output logic comparator_output,
  output logic system_clock_output,
  output logic async_serial_transmit,
  output logic async_serial_receive_en,
  output logic timer0_input_route,
  output logic timer1_input_route,
  output logic counter_external_input_route,
  output logic output_drivers_en,
  output logic weak_pullup_en
);
  // ----------------------------------------
  // Registers and bus slave
  // ----------------------------------------
  logic [7:0] low_q, low_d;
  logic [7:0] high_q, high_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] resp_q, resp_d;
  logic wait_q, wait_d;
  bus_state_t st_q, st_d;
  logic [13:0] route_en;
  logic [1:0] cmp_sync_q;
  logic [1:0] cmp_sync_d;
  logic hit;
  logic sel_low, sel_high, sel_status, sel_mode;
  logic [31:0] rd_word;
  // ----------------------------------------
  // Configuration carrier and route decode
  // ----------------------------------------
  xbar_cfg_if cfg();
  assign cfg.low = low_q;
  assign cfg.high = high_q;
  assign cfg.four_wire = spi_four_wire;
  assign route_en = cfg.route_en;
  xbar_route_decode u_decode (
    .cfg(cfg)
  );
  // Index decode, shared by the read mux and the write path
  always_comb begin
    sel_low = (avs_address == select_low_index);
    sel_high = (avs_address == select_high_index);
    sel_status = (avs_address == route_status_index);
    sel_mode = (avs_address == spi_mode_index);
    // Unmapped indexes still get an answer so a stray access never hangs the master
    hit = sel_low || sel_high || sel_status || sel_mode;
    rd_word = 32'h0;
    if (sel_low) begin
      rd_word = {24'h0, low_q & select_low_mask};
    end
    if (sel_high) begin
      rd_word = {24'h0, high_q};
    end
    if (sel_status) begin
      rd_word = {18'h0, route_en};
    end
    if (sel_mode) begin
      rd_word = {31'h0, spi_four_wire};
    end
  end
  // ----------------------------------------
  // Bus next state
  // ----------------------------------------
  // One-wait-state slave: answer in the cycle after the request is seen
  always_comb begin
    low_d = low_q;
    high_d = high_q;
    rdata_d = rdata_q;
    resp_d = resp_q;
    wait_d = 1'b1;
    st_d = st_q;
    unique case (st_q)
      bus_idle: begin
        if (avs_read || avs_write) begin
          st_d = bus_ack;
          wait_d = 1'b0;
          resp_d = hit ? 2'h0 : 2'h2;
          rdata_d = avs_read ? rd_word : 32'h0;
        end
      end
      // The write lands at the edge where the master sees waitrequest low, while
      // it still holds the request; clk_en must stay high across a transfer
      bus_ack: begin
        st_d = bus_idle;
        if (avs_write && avs_byteenable[0] && sel_low) begin
          low_d = avs_writedata[7:0] & select_low_mask;
        end
        if (avs_write && avs_byteenable[0] && sel_high) begin
          high_d = avs_writedata[7:0] & select_high_mask;
        end
      end
      default: begin
        st_d = bus_idle;
      end
    endcase
  end
  // ----------------------------------------
  // Bus registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      low_q <= select_low_reset;
      high_q <= select_high_reset;
      rdata_q <= 32'h0;
      resp_q <= 2'h0;
      wait_q <= 1'b1;
      st_q <= bus_idle;
    end else if (clk_en) begin
      low_q <= low_d;
      high_q <= high_d;
      rdata_q <= rdata_d;
      resp_q <= resp_d;
      wait_q <= wait_d;
      st_q <= st_d;
    end
  end
  // The bus outputs are the flops themselves, so nothing combinational reaches the master
  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign avs_response = resp_q;
  // ----------------------------------------
  // Pin-side outputs, all registered
  // ----------------------------------------
  // Async comparator crosses in through two flops before reaching a pin;
  // that costs two cycles of latency but keeps every pin output registered
  logic [13:0] drive_d, oe_d;
  logic en;
  logic cmp_pin_d, system_clock_output_pin_d, tx_pin_d, rx_en_d;
  logic t0_route_d, t1_route_d, eci_route_d, drivers_en_d, pullup_en_d;
  // ----------------------------------------
  // Per-function drive and enable
  // ----------------------------------------
  // Each slot passes its peripheral level and its route; the async comparator
  // slot carries the synced copy instead of the raw input
  for (genvar i = 0; i < num_func; i++) begin : g_func
    if (i == fn_cp_async) begin : g_cmp
      assign drive_d[i] = cmp_sync_q[1];
    end else begin : g_pass
      assign drive_d[i] = func_out[i];
    end
    assign oe_d[i] = route_en[i];
  end
  // ----------------------------------------
  // Level outputs
  // ----------------------------------------
  always_comb begin
    cmp_sync_d = {cmp_sync_q[0], comparator_async_in};
    en = high_q[matrix_enable_pos];
    cmp_pin_d = route_en[fn_cp_sync] & func_out[fn_cp_sync];
    system_clock_output_pin_d = route_en[fn_system_clock_output] & func_out[fn_system_clock_output];
    tx_pin_d = route_en[fn_tx] & func_out[fn_tx];
    rx_en_d = route_en[fn_rx];
    t0_route_d = en & high_q[timer0_input_route_en_pos];
    t1_route_d = en & high_q[timer1_input_route_en_pos];
    eci_route_d = en & high_q[counter_ext_input_route_en_pos];
    drivers_en_d = en;
    pullup_en_d = ~high_q[pullup_disable_pos];
  end
  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cmp_sync_q <= sync_reset;
      func_drive <= 14'h0;
      func_oe <= 14'h0;
      comparator_output <= 1'b0;
      system_clock_output <= 1'b0;
      async_serial_transmit <= 1'b0;
      async_serial_receive_en <= 1'b0;
      timer0_input_route <= 1'b0;
      timer1_input_route <= 1'b0;
      counter_external_input_route <= 1'b0;
      output_drivers_en <= 1'b0;
      // Pull-ups default on so open-drain pins do not float out of reset
      weak_pullup_en <= 1'b1;
    end else if (clk_en) begin
      cmp_sync_q <= cmp_sync_d;
      func_drive <= drive_d;
      func_oe <= oe_d;
      comparator_output <= cmp_pin_d;
      system_clock_output <= system_clock_output_pin_d;
      async_serial_transmit <= tx_pin_d;
      async_serial_receive_en <= rx_en_d;
      timer0_input_route <= t0_route_d;
      timer1_input_route <= t1_route_d;
      counter_external_input_route <= eci_route_d;
      output_drivers_en <= drivers_en_d;
      weak_pullup_en <= pullup_en_d;
    end
  end
endmodule
`default_nettype wire

// [sim/xbar_route_props.sv]
`timescale 1ns/1ps
`default_nettype none
module xbar_route_props
  import xbar_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [13:0] func_out,
  input wire logic [13:0] func_oe,
  input wire logic comparator_output,
  input wire logic system_clock_output,
  input wire logic async_serial_transmit,
  input wire logic output_drivers_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  low_top_zero_a: assert property (!avs_waitrequest && avs_read && avs_address == select_low_index
    |-> avs_readdata[7:6] == 2'h0) else $error("low register top bits not zero");
  sync_comp_a: assert property ($past(clk_en)
    |-> comparator_output == (func_oe[fn_cp_sync] && $past(func_out[fn_cp_sync])))
    else $error("comparator output not following its source");
  system_clock_output_out_a: assert property ($past(clk_en)
    |-> system_clock_output == (func_oe[fn_system_clock_output] && $past(func_out[fn_system_clock_output])))
    else $error("clock output not following its source");
  twowire_pair_a: assert property (func_oe[6] == func_oe[7]) else $error("two-wire pins split");
  spi_select_a: assert property (func_oe[5] |-> func_oe[4] && func_oe[2]) else $error("select without spi");
  uart_tx_a: assert property ($past(clk_en)
    |-> async_serial_transmit == (func_oe[fn_tx] && $past(func_out[fn_tx])))
    else $error("transmit not following its source");
  matrix_off_a: assert property (!output_drivers_en |-> func_oe == 14'h0)
    else $error("drivers on while matrix off");
  capture_order_a: assert property (func_oe[12] |-> func_oe[11]) else $error("capture lines out of order");
  cover property (func_oe[5]);
  cover property (func_oe[13]);
  cover property (!avs_waitrequest && avs_read);
endmodule
bind port_crossbar_routing xbar_route_props props_i (.ref_clk, .rstn, .clk_en, .avs_address, .avs_read,
  .avs_readdata, .avs_waitrequest, .func_out, .func_oe, .comparator_output, .system_clock_output,
  .async_serial_transmit, .output_drivers_en);
`default_nettype wire

// [sim/periph_model.sv]
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input wire logic ref_clk,
  output logic [13:0] func_out,
  output logic comparator_async_in
);
  integer seed = 32'hce86;
  initial begin
    func_out = 14'h0;
    comparator_async_in = 1'b0;
  end
  // Levels change every cycle so a stale or wrong route shows up
  always @(posedge ref_clk) begin
    func_out <= 14'($random(seed));
    comparator_async_in <= 1'($random(seed));
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import xbar_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic spi_four_wire = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] avs_response;
  logic [13:0] func_out, func_drive, func_oe, exp_oe;
  logic comparator_output, system_clock_output, async_serial_transmit, async_serial_receive_en;
  logic timer0_input_route, timer1_input_route, counter_external_input_route, output_drivers_en, weak_pullup_en;
  logic comparator_async_in;
  logic [33:0] rd_q[$];
  logic [7:0] lo, hi;
  int errors = 0;
  int num_checks = 0;
  integer seed = 32'hce86;
  logic [13:0] prev_out, held;
  logic [2:0] cmp_hist;
  int live = 0;
  always #25 ref_clk = ~ref_clk;
  periph_model peer (.ref_clk, .func_out, .comparator_async_in);
  port_crossbar_routing dut (.ref_clk, .rstn, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .spi_four_wire,
    .comparator_async_in, .func_out, .func_drive, .func_oe, .comparator_output, .system_clock_output,
    .async_serial_transmit, .async_serial_receive_en, .timer0_input_route, .timer1_input_route,
    .counter_external_input_route, .output_drivers_en, .weak_pullup_en);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Request held until the edge that sees waitrequest low
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= ~rd;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      errors++;
      print_verdict();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    bus(1'b1, a, 32'h0);
  endtask
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0 && rd_q.size() > 0) begin
      chk({avs_response, avs_readdata}, rd_q.pop_front(), "read");
    end
  end
  // Pin drive follows the peripheral level one cycle late, the comparator three
  always @(posedge ref_clk) begin
    if (live >= 3) begin
      chk({20'h0, func_drive}, {20'h0, prev_out[13:9], cmp_hist[2], prev_out[7:0]}, "pin drive");
    end
    prev_out <= func_out;
    cmp_hist <= {cmp_hist[1:0], comparator_async_in};
    live <= (rstn && clk_en) ? live + 1 : 0;
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(select_low_index, 34'h0);
    rd(select_high_index, 34'h0);
    for (int i = 0; i < 16; i++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      hi[1:0] = 2'(i);
      if (i == 15) begin
        lo = 8'hff;
        hi = 8'h7f;
      end
      spi_four_wire <= 1'($random(seed));
      bus(1'b0, select_low_index, {24'h0, lo});
      bus(1'b0, select_high_index, {24'h0, hi});
      rd(select_low_index, {26'h0, lo & select_low_mask});
      rd(select_high_index, {26'h0, hi & select_high_mask});
      repeat (3) @(posedge ref_clk);
      exp_oe = {hi[1:0] == 2'h3, hi[1:0] > 2'h1, hi[1:0] != 2'h0, lo[3], lo[4], lo[5], lo[2], lo[2],
        lo[1] & spi_four_wire, {3{lo[1]}}, lo[0], lo[0]} & {14{hi[6]}};
      chk({20'h0, func_oe}, {20'h0, exp_oe}, "route enables");
      chk({28'h0, async_serial_receive_en, timer1_input_route, timer0_input_route, counter_external_input_route,
        output_drivers_en, weak_pullup_en}, {28'h0, lo[0] & hi[6], hi[5] & hi[6], hi[4] & hi[6], hi[3] & hi[6],
        hi[6], ~hi[7]}, "levels");
      $display("routing test %0d done", i);
    end
    bus(1'b0, 8'h10, 32'h0);
    rd(8'h10, {2'b10, 32'h0});
    avs_byteenable <= 4'he;
    bus(1'b0, select_low_index, 32'h0);
    avs_byteenable <= 4'hf;
    rd(select_low_index, {26'h0, lo & select_low_mask});
    $display("unmapped test done");
    clk_en <= 1'b0;
    @(posedge ref_clk);
    held = func_drive;
    repeat (4) @(posedge ref_clk);
    chk({20'h0, func_drive}, {20'h0, held}, "frozen drive");
    clk_en <= 1'b1;
    $display("freeze test done");
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(select_low_index, 34'h0);
    rd(select_high_index, 34'h0);
    repeat (2) @(posedge ref_clk);
    chk({20'h0, func_oe}, 34'h0, "oe after reset");
    chk({32'h0, output_drivers_en, weak_pullup_en}, 34'h1, "levels after reset");
    $display("reset test done");
    chk(34'(rd_q.size()), 34'h0, "reads left");
    @(posedge ref_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
